/* File: rtl/uefsm_map.vh */
`ifndef UEFSM_MAP_VH
`define UEFSM_MAP_VH
// Enumeration states
`define UEF_ST_POWERED 2'h0
`define UEF_ST_DEFAULT 2'h1
`define UEF_ST_ADDRESS 2'h2
`define UEF_ST_CONFIG 2'h3
// Default device address
`define UEF_ADDR_DEFAULT 7'h00
// Standard request codes
`define UEF_REQ_SET_ADDRESS 8'h05
`define UEF_REQ_GET_DESC 8'h06
`define UEF_REQ_SET_CONFIG 8'h09
// Descriptor types carried in the request value high byte
`define UEF_DT_DEVICE 8'h01
`define UEF_DT_CONFIG 8'h02
// Descriptor store layout
`define UEF_DEV_BASE 6'h00
`define UEF_DEV_LEN 16'h0012
`define UEF_CFG_BASE 6'h12
`define UEF_CFG_LEN 16'h0019
`define UEF_MPS_OFS 6'h07
// Valid configuration value
`define UEF_CFG_VALUE 8'h01
`define UEF_CFG_NONE 8'h00
// Timing
`define UEF_CLK_NS 100
`define UEF_SE0_NS 2500
`define UEF_CHIRP_K_US 1000
`define UEF_CHIRP_WAIT_US 2000
`define UEF_KJ_COUNT 3'h6
`endif

/* File: rtl/uefsm_top.v */
// Overview of operation
// - Keep current within 100 mA until configured; low-power output asserted.
// - Attach by enabling pull-up on one data line chosen by speed.
// - Both lines low longer than 2.5 us is taken as bus reset; the code ignores SE0 once in high speed.
// - High-speed capable device drives one single K during reset.
// - On seeing the KJ reply, drop D+ pull-up and run high speed.
// - Low or full speed only devices skip the K announcement.
// - After reset enter default state, answer control transfers at address 00h.
// - Device descriptor byte eight holds endpoint zero maximum packet size.
// - At default address return at least first 8 device descriptor bytes.
// - Tolerate status stage after 8 of 64 bytes, then a reset.
// - Finish set-address status at 00h, only then take new address.
// - After address change answer only at new address, in address state.
// - Detach or port reset discards address, back to default address.
// - Configuration request returns config, interface, endpoint descriptors, truncated.
// - Valid set-configuration enters configured state, enables its endpoints.
// - Full power permit only while configured.
`timescale 1ns/10ps
`include "uefsm_map.vh"

module uefsm_top #(
  parameter EP0_MPS = 8,
  parameter HS_CAPABLE = 1,
  parameter LOW_SPEED = 0,
  parameter [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
  parameter [15:0] PRODUCT_CODE = 16'h5678, // Arbitrary value
  parameter [7:0] MAX_POWER = 8'h32,
  parameter CHIRP_K_CYC = (`UEF_CHIRP_K_US * 1000) / `UEF_CLK_NS,
  parameter CHIRP_WAIT_CYC = (`UEF_CHIRP_WAIT_US * 1000) / `UEF_CLK_NS
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Attach sense
  input wire vbus_on,
  // Data line pins
  input wire dp_in,
  input wire dm_in,
  output reg dp_out_r,
  output reg dm_out_r,
  output reg dp_oe_r,
  output reg dm_oe_r,
  output reg pullup_dp_r,
  output reg pullup_dm_r,
  output reg hs_mode_r,
  // Token side from packet engine
  input wire [6:0] tok_addr,
  input wire setup_valid,
  input wire [7:0] setup_req,
  input wire [15:0] setup_value,
  input wire [15:0] setup_length,
  input wire in_req,
  input wire status_done,
  // Data stage bytes to packet engine
  output reg tx_valid_r,
  output reg [7:0] tx_byte_r,
  output reg tx_last_r,
  output reg tx_zlp_r,
  output reg stall_r,
  // Status and power
  output reg [1:0] state_r,
  output reg [6:0] dev_addr_r,
  output reg ep_enable_r,
  output reg pwr_low_r,
  output reg pwr_full_r,
  output reg state_evt_r,
  output reg bus_rst_evt_r
);

  localparam SE0_CYC = (`UEF_SE0_NS + `UEF_CLK_NS - 1) / `UEF_CLK_NS;
  localparam [1:0] LK_IDLE = 2'h0;
  localparam [1:0] LK_CHIRP = 2'h1;
  localparam [1:0] LK_WAITKJ = 2'h2;
  localparam [1:0] LK_RESET = 2'h3;
  localparam [7:0] MPS8 = EP0_MPS;
  localparam [15:0] CFG_LEN = `UEF_CFG_LEN;

  reg [1:0] link_r;
  reg [1:0] link_nxt;
  reg [15:0] se0_cnt_r;
  reg [23:0] tim_r;
  reg [2:0] kj_cnt_r;
  reg last_k_r;
  reg in_reset_r;
  reg [1:0] st_nxt;
  reg [6:0] pend_addr_r;
  reg addr_pend_r;
  reg data_stage_r;
  reg sending_r;
  reg [5:0] ptr_r;
  reg [15:0] rem_r;
  reg [7:0] pkt_cnt_r;
  reg [7:0] rom_byte;
  wire se0 = ~dp_in & ~dm_in;
  wire line_k = ~dp_in & dm_in;
  wire line_j = dp_in & ~dm_in;
  wire attached = vbus_on;
  wire bus_rst = (se0_cnt_r == SE0_CYC[15:0]) && (link_r == LK_IDLE) && !hs_mode_r;
  wire addr_ok = (tok_addr == dev_addr_r) && (state_r != `UEF_ST_POWERED);
  wire setup_ok = setup_valid && addr_ok && !in_reset_r;
  wire [15:0] dev_len = (setup_length < `UEF_DEV_LEN) ? setup_length : `UEF_DEV_LEN;
  wire [15:0] cfg_len = (setup_length < `UEF_CFG_LEN) ? setup_length : `UEF_CFG_LEN;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor store
  // Device descriptor, then configuration, interface and endpoint in order
  always @* begin
    case (ptr_r)
      6'h00: rom_byte = 8'h12;
      6'h01: rom_byte = 8'h01;
      6'h03: rom_byte = 8'h02;
      `UEF_MPS_OFS: rom_byte = MPS8;
      6'h08: rom_byte = VENDOR_CODE[7:0];
      6'h09: rom_byte = VENDOR_CODE[15:8];
      6'h0A: rom_byte = PRODUCT_CODE[7:0];
      6'h0B: rom_byte = PRODUCT_CODE[15:8];
      6'h0D: rom_byte = 8'h01;
      6'h11: rom_byte = 8'h01;
      6'h12: rom_byte = 8'h09;
      6'h13: rom_byte = 8'h02;
      6'h14: rom_byte = CFG_LEN[7:0];
      6'h15: rom_byte = CFG_LEN[15:8];
      6'h16: rom_byte = 8'h01;
      6'h17: rom_byte = `UEF_CFG_VALUE;
      6'h19: rom_byte = 8'h80;
      6'h1A: rom_byte = MAX_POWER;
      6'h1B: rom_byte = 8'h09;
      6'h1C: rom_byte = 8'h04;
      6'h1F: rom_byte = 8'h01;
      6'h20: rom_byte = 8'hFF;
      6'h24: rom_byte = 8'h07;
      6'h25: rom_byte = 8'h05;
      6'h26: rom_byte = 8'h81;
      6'h27: rom_byte = 8'h02;
      6'h28: rom_byte = MPS8;
      // Bytes not listed are zero
      default: rom_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus reset and chirp handshake
  // Next link state
  always @* begin
    link_nxt = link_r;
    case (link_r)
      LK_IDLE: begin
        if (bus_rst)
          link_nxt = (HS_CAPABLE != 0 && LOW_SPEED == 0) ? LK_CHIRP : LK_RESET;
      end
      LK_CHIRP: begin
        if (tim_r == CHIRP_K_CYC[23:0])
          link_nxt = LK_WAITKJ;
      end
      LK_WAITKJ: begin
        if (kj_cnt_r == `UEF_KJ_COUNT || tim_r == CHIRP_WAIT_CYC[23:0])
          link_nxt = LK_RESET;
      end
      default: begin
        if (!se0 || hs_mode_r)
          link_nxt = LK_IDLE;
      end
    endcase
  end

  // Link registers and pin drive
  always @(posedge clk) begin
    if (!rst_n || !attached) begin
      link_r <= LK_IDLE;
      se0_cnt_r <= 16'h0000;
      tim_r <= 24'h000000;
      kj_cnt_r <= 3'h0;
      last_k_r <= 1'b0;
      in_reset_r <= 1'b0;
      hs_mode_r <= 1'b0;
      dp_out_r <= 1'b0;
      dm_out_r <= 1'b0;
      dp_oe_r <= 1'b0;
      dm_oe_r <= 1'b0;
      pullup_dp_r <= 1'b0;
      pullup_dm_r <= 1'b0;
    end else begin
      link_r <= link_nxt;
      if (!se0 || link_r != LK_IDLE)
        se0_cnt_r <= 16'h0000;
      else if (se0_cnt_r != SE0_CYC[15:0])
        se0_cnt_r <= se0_cnt_r + 16'h0001;
      tim_r <= (link_nxt != link_r) ? 24'h000000 : tim_r + 24'h000001;
      in_reset_r <= (link_nxt != LK_IDLE);
      pullup_dm_r <= (LOW_SPEED != 0);
      // drop D+ pull-up in high speed
      pullup_dp_r <= (LOW_SPEED == 0) && !hs_mode_r &&
                     !(link_r == LK_WAITKJ && kj_cnt_r == `UEF_KJ_COUNT);
      if (link_r == LK_WAITKJ && kj_cnt_r == `UEF_KJ_COUNT)
        hs_mode_r <= 1'b1;
      else if (link_r == LK_IDLE && bus_rst)
        hs_mode_r <= 1'b0;
      dp_out_r <= 1'b0;
      dm_out_r <= (link_nxt == LK_CHIRP);
      dp_oe_r <= (link_nxt == LK_CHIRP);
      dm_oe_r <= (link_nxt == LK_CHIRP);
      if (link_r != LK_WAITKJ) begin
        kj_cnt_r <= 3'h0;
        last_k_r <= 1'b0;
      end else if (kj_cnt_r != `UEF_KJ_COUNT) begin
        if (line_k && (kj_cnt_r == 3'h0 || !last_k_r)) begin
          kj_cnt_r <= kj_cnt_r + 3'h1;
          last_k_r <= 1'b1;
        end else if (line_j && last_k_r) begin
          kj_cnt_r <= kj_cnt_r + 3'h1;
          last_k_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enumeration state
  // Next enumeration state
  always @* begin
    st_nxt = state_r;
    if (!attached) begin
      st_nxt = `UEF_ST_POWERED;
    end else if (in_reset_r || bus_rst) begin
      st_nxt = `UEF_ST_DEFAULT;
    end else if (status_done && addr_ok && addr_pend_r) begin
      st_nxt = (pend_addr_r == `UEF_ADDR_DEFAULT) ? `UEF_ST_DEFAULT : `UEF_ST_ADDRESS;
    end else if (setup_ok && setup_req == `UEF_REQ_SET_CONFIG &&
                 state_r != `UEF_ST_DEFAULT) begin
      if (setup_value[7:0] == `UEF_CFG_VALUE)
        st_nxt = `UEF_ST_CONFIG;
      else if (setup_value[7:0] == `UEF_CFG_NONE)
        st_nxt = `UEF_ST_ADDRESS;
    end
  end

  always @(posedge clk) begin
    if (!rst_n)
      state_evt_r <= 1'b0;
    else
      state_evt_r <= (st_nxt != state_r);
  end

  // State, address and power registers
  always @(posedge clk) begin
    if (!rst_n || !attached) begin
      state_r <= `UEF_ST_POWERED;
      dev_addr_r <= `UEF_ADDR_DEFAULT;
      pend_addr_r <= `UEF_ADDR_DEFAULT;
      addr_pend_r <= 1'b0;
      ep_enable_r <= 1'b0;
      pwr_low_r <= 1'b1;
      pwr_full_r <= 1'b0;
      bus_rst_evt_r <= 1'b0;
    end else begin
      state_r <= st_nxt;
      bus_rst_evt_r <= bus_rst;
      if (in_reset_r || bus_rst) begin
        dev_addr_r <= `UEF_ADDR_DEFAULT;
        addr_pend_r <= 1'b0;
      end else if (status_done && addr_ok && addr_pend_r) begin
        dev_addr_r <= pend_addr_r;
        addr_pend_r <= 1'b0;
      end else if (setup_ok) begin
        addr_pend_r <= (setup_req == `UEF_REQ_SET_ADDRESS);
        pend_addr_r <= setup_value[6:0];
      end
      ep_enable_r <= (st_nxt == `UEF_ST_CONFIG);
      pwr_low_r <= (st_nxt != `UEF_ST_CONFIG);
      pwr_full_r <= (st_nxt == `UEF_ST_CONFIG);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor data stage
  // Request decode and packet streaming
  always @(posedge clk) begin
    if (!rst_n || !attached || in_reset_r || bus_rst) begin
      data_stage_r <= 1'b0;
      sending_r <= 1'b0;
      ptr_r <= `UEF_DEV_BASE;
      rem_r <= 16'h0000;
      pkt_cnt_r <= 8'h00;
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
      tx_last_r <= 1'b0;
      tx_zlp_r <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
      tx_zlp_r <= 1'b0;
      stall_r <= 1'b0;
      if (setup_ok) begin
        sending_r <= 1'b0;
        data_stage_r <= 1'b0;
        if (setup_req == `UEF_REQ_GET_DESC && setup_value[15:8] == `UEF_DT_DEVICE) begin
          data_stage_r <= 1'b1;
          ptr_r <= `UEF_DEV_BASE;
          rem_r <= dev_len;
        end else if (setup_req == `UEF_REQ_GET_DESC &&
                     setup_value[15:8] == `UEF_DT_CONFIG) begin
          data_stage_r <= 1'b1;
          ptr_r <= `UEF_CFG_BASE;
          rem_r <= cfg_len;
        end else if (setup_req != `UEF_REQ_SET_ADDRESS &&
                     setup_req != `UEF_REQ_SET_CONFIG) begin
          stall_r <= 1'b1;
        end
      end else if (status_done && addr_ok) begin
        data_stage_r <= 1'b0;
        sending_r <= 1'b0;
      end else if (sending_r) begin
        tx_valid_r <= 1'b1;
        tx_byte_r <= rom_byte;
        ptr_r <= ptr_r + 6'h01;
        rem_r <= rem_r - 16'h0001;
        pkt_cnt_r <= pkt_cnt_r + 8'h01;
        if (rem_r == 16'h0001 || pkt_cnt_r == MPS8 - 8'h01) begin
          tx_last_r <= 1'b1;
          sending_r <= 1'b0;
          if (rem_r == 16'h0001 && pkt_cnt_r != MPS8 - 8'h01)
            data_stage_r <= 1'b0;
        end
      end else if (in_req && addr_ok && data_stage_r) begin
        pkt_cnt_r <= 8'h00;
        if (rem_r == 16'h0000) begin
          tx_zlp_r <= 1'b1;
          data_stage_r <= 1'b0;
        end else begin
          sending_r <= 1'b1;
        end
      end
    end
  end

endmodule // uefsm_top

/* File: test/uefsm_checker.sv */
`timescale 1ns/10ps
`include "uefsm_map.vh"
// Port checks of the enumeration block
module uefsm_checker #(parameter EP0_MPS = 8) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Line and token inputs
  input wire dp_in,
  input wire dm_in,
  input wire setup_valid,
  input wire in_req,
  input wire status_done,
  // Outputs watched
  input wire dm_oe_r,
  input wire dm_out_r,
  input wire pullup_dp_r,
  input wire hs_mode_r,
  input wire tx_valid_r,
  input wire tx_last_r,
  input wire [1:0] state_r,
  input wire [6:0] dev_addr_r,
  input wire pwr_low_r,
  input wire pwr_full_r,
  input wire state_evt_r,
  input wire bus_rst_evt_r
);
  reg [4:0] se0_cnt_r;
  reg [7:0] pkt_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // SE0 run length and bytes in the open packet
  always @(posedge clk) begin
    if (!rst_n || dp_in || dm_in) se0_cnt_r <= 5'h00;
    else if (se0_cnt_r != 5'h1F) se0_cnt_r <= se0_cnt_r + 5'h01;
    if (!rst_n || tx_last_r || setup_valid || in_req || status_done) pkt_cnt_r <= 8'h00;
    else if (tx_valid_r) pkt_cnt_r <= pkt_cnt_r + 8'h01;
  end
  a_rst_after_se0: assert property (bus_rst_evt_r |-> se0_cnt_r >= 5'h19)
    else $error("reset seen without long SE0");
  a_chirp_k_drive: assert property ($rose(bus_rst_evt_r) |-> ##[0:2] (dm_oe_r && dm_out_r))
    else $error("no K after bus reset");
  a_chirp_in_reset: assert property (dm_oe_r |-> !hs_mode_r && state_r != `UEF_ST_CONFIG)
    else $error("K driven outside reset");
  a_hs_pullup_off: assert property (hs_mode_r |-> !pullup_dp_r)
    else $error("pull-up kept in high speed");
  a_rst_to_default: assert property (bus_rst_evt_r |=> state_r == `UEF_ST_DEFAULT)
    else $error("not default after reset");
  a_addr_after_status: assert property ($changed(dev_addr_r) |-> $past(status_done)
    || dev_addr_r == `UEF_ADDR_DEFAULT)
    else $error("address taken before status");
  a_addr_state_set: assert property ($changed(dev_addr_r) && dev_addr_r != 7'h00
    |-> state_r == `UEF_ST_ADDRESS)
    else $error("new address outside address state");
  a_power_config: assert property (pwr_full_r |-> state_r == `UEF_ST_CONFIG && !pwr_low_r)
    else $error("full power unconfigured");
  a_state_event: assert property ($changed(state_r) |-> state_evt_r)
    else $error("state change without event");
  a_packet_size: assert property (tx_valid_r |-> pkt_cnt_r < EP0_MPS)
    else $error("packet over max size");
  c_hs_done: cover property ($rose(hs_mode_r));
  c_addressed: cover property (state_r == `UEF_ST_ADDRESS);
  c_configured: cover property ($rose(pwr_full_r));
endmodule // uefsm_checker

bind uefsm_top uefsm_checker #(.EP0_MPS(EP0_MPS)) u_uefsm_checker (
  .clk(clk), .rst_n(rst_n), .dp_in(dp_in), .dm_in(dm_in), .setup_valid(setup_valid),
  .in_req(in_req), .status_done(status_done), .dm_oe_r(dm_oe_r), .dm_out_r(dm_out_r),
  .pullup_dp_r(pullup_dp_r), .hs_mode_r(hs_mode_r), .tx_valid_r(tx_valid_r),
  .tx_last_r(tx_last_r), .state_r(state_r), .dev_addr_r(dev_addr_r), .pwr_low_r(pwr_low_r),
  .pwr_full_r(pwr_full_r), .state_evt_r(state_evt_r), .bus_rst_evt_r(bus_rst_evt_r));

/* File: test/uefsm_hub_model.sv */
`timescale 1ns/10ps
// Upstream hub port: reset signalling and chirp reply
module uefsm_hub_model #(parameter RST_CYC = 150) (
  input wire clk,
  input wire go_rst,
  input wire pu_dp,
  input wire pu_dm,
  input wire dp_out,
  input wire dm_out,
  input wire dp_oe,
  input wire dm_oe,
  output wire dp_in,
  output wire dm_in
);
  reg [1:0] drv_r = 2'h0;
  reg idle_r = 1'b1;
  reg k_r;
  int n;
  int i;
  // Idle line follows the pull-ups, otherwise the hub drives SE0 and then its K/J chirps
  assign dp_in = dp_oe ? dp_out : (idle_r ? pu_dp : drv_r[1]);
  assign dm_in = dm_oe ? dm_out : (idle_r ? pu_dm : drv_r[0]);
  initial begin
    forever begin
      @(posedge go_rst);
      idle_r = 1'b0;
      drv_r = 2'h0;
      k_r = 1'b0;
      for (n = 0; n < RST_CYC; n++) begin
        @(posedge clk);
        #10;
        if (dm_oe && dm_out) k_r = 1'b1;
        else if (k_r) begin
          for (i = 0; i < 6; i++) begin
            drv_r = i[0] ? 2'h2 : 2'h1;
            repeat (2) @(posedge clk);
            #10;
          end
          n = RST_CYC;
        end
      end
      idle_r = 1'b1;
    end
  end
endmodule // uefsm_hub_model

/* File: test/uefsm_tb_top.sv */
`timescale 1ns/10ps
`include "uefsm_map.vh"
module uefsm_tb_top;
  reg clk = 1'b0;
  reg rst_n, vbus_on, go_rst, setup_valid, in_req, status_done;
  reg [6:0] tok_addr;
  reg [7:0] setup_req;
  reg [15:0] setup_value, setup_length;
  wire dp_in, dm_in, dp_out_r, dm_out_r, dp_oe_r, dm_oe_r, pullup_dp_r, pullup_dm_r, hs_mode_r;
  wire tx_valid_r, tx_last_r, ep_enable_r, pwr_low_r, pwr_full_r, bus_rst_evt_r;
  wire tx_zlp_r, stall_r, state_evt_r;
  wire [7:0] tx_byte_r;
  wire [1:0] state_r;
  wire [6:0] dev_addr_r;
  reg [7:0] rx_buf [0:31];
  int rx_n, n_last, n_rst_evt, n_mismatch, cmp_count, k;
  int n_zlp, n_stall, n_state_evt;
  always #50 clk = ~clk;
  // lone device at address zero
  // Block with shortened chirp spans
  uefsm_top #(.CHIRP_K_CYC(20), .CHIRP_WAIT_CYC(60)) u_uefsm_top (
    .clk(clk), .rst_n(rst_n), .vbus_on(vbus_on), .dp_in(dp_in), .dm_in(dm_in),
    .dp_out_r(dp_out_r), .dm_out_r(dm_out_r), .dp_oe_r(dp_oe_r), .dm_oe_r(dm_oe_r),
    .pullup_dp_r(pullup_dp_r), .pullup_dm_r(pullup_dm_r), .hs_mode_r(hs_mode_r),
    .tok_addr(tok_addr), .setup_valid(setup_valid), .setup_req(setup_req),
    .setup_value(setup_value), .setup_length(setup_length), .in_req(in_req),
    .status_done(status_done), .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r),
    .tx_last_r(tx_last_r), .tx_zlp_r(tx_zlp_r), .stall_r(stall_r), .state_r(state_r),
    .dev_addr_r(dev_addr_r), .ep_enable_r(ep_enable_r), .pwr_low_r(pwr_low_r),
    .pwr_full_r(pwr_full_r), .state_evt_r(state_evt_r), .bus_rst_evt_r(bus_rst_evt_r));
  uefsm_hub_model #(.RST_CYC(150)) u_uefsm_hub_model (
    .clk(clk), .go_rst(go_rst), .pu_dp(pullup_dp_r), .pu_dm(pullup_dm_r),
    .dp_out(dp_out_r), .dm_out(dm_out_r), .dp_oe(dp_oe_r), .dm_oe(dm_oe_r),
    .dp_in(dp_in), .dm_in(dm_in));
  // Byte and event capture on the quiet edge
  always @(negedge clk) begin
    if (tx_valid_r === 1'b1) begin
      rx_buf[rx_n[4:0]] = tx_byte_r;
      rx_n++;
    end
    if (tx_last_r === 1'b1) n_last++;
    if (bus_rst_evt_r === 1'b1) n_rst_evt++;
    if (tx_zlp_r === 1'b1) n_zlp++;
    if (stall_r === 1'b1) n_stall++;
    if (state_evt_r === 1'b1) n_state_evt++;
  end
  ////////////////////////////////////////////////////////////
  task step;
    @(posedge clk);
    #10;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task setup(input [6:0] a, input [7:0] r, input [15:0] v, input [15:0] l);
    tok_addr = a;
    setup_req = r;
    setup_value = v;
    setup_length = l;
    setup_valid = 1'b1;
    step;
    setup_valid = 1'b0;
    step;
  endtask
  task status(input [6:0] a);
    tok_addr = a;
    status_done = 1'b1;
    step;
    status_done = 1'b0;
    step;
  endtask
  task read_pkt(input [6:0] a);
    tok_addr = a;
    in_req = 1'b1;
    step;
    in_req = 1'b0;
    for (k = 0; k < 12 && tx_last_r !== 1'b1; k++) step;
    step;
  endtask
  task bus_reset;
    go_rst = 1'b1;
    step;
    go_rst = 1'b0;
    for (k = 0; k < 400 && hs_mode_r !== 1'b1; k++) step;
    step;
  endtask
  ////////////////////////////////////////////////////////////
  task t_attach;
    chk(state_r, `UEF_ST_POWERED);
    chk(pwr_low_r, 1'b1);
    chk(pullup_dp_r, 1'b1);
    chk(pullup_dm_r, 1'b0);
    bus_reset;
    chk(n_rst_evt, 16'h0001);
    chk(hs_mode_r, 1'b1);
    chk(pullup_dp_r, 1'b0);
    chk(state_r, `UEF_ST_DEFAULT);
    chk(n_state_evt, 16'h0001);
  endtask
  task t_dev_desc;
    rx_n = 0;
    setup(7'h00, `UEF_REQ_GET_DESC, {`UEF_DT_DEVICE, 8'h00}, 16'h0040);
    read_pkt(7'h00);
    status(7'h00);
    chk(rx_n, 16'h0008);
    chk(rx_buf[7], 16'h0008);
    rx_n = 0;
    n_last = 0;
    setup(7'h00, `UEF_REQ_GET_DESC, {`UEF_DT_DEVICE, 8'h00}, 16'h0012);
    repeat (3) read_pkt(7'h00);
    chk(rx_n, 16'h0012);
    chk(n_last, 16'h0003);
    chk(rx_buf[0], 16'h0012);
    // exact multiple ends in empty packet
    setup(7'h00, `UEF_REQ_GET_DESC, {`UEF_DT_DEVICE, 8'h00}, 16'h0010);
    repeat (3) read_pkt(7'h00);
    chk(n_zlp, 16'h0001);
    setup(7'h00, 8'h03, 16'h0000, 16'h0000);
    chk(n_stall, 16'h0001);
  endtask
  task t_set_addr;
    setup(7'h00, `UEF_REQ_SET_CONFIG, 16'h0001, 16'h0000);
    chk(state_r, `UEF_ST_DEFAULT);
    setup(7'h00, `UEF_REQ_SET_ADDRESS, 16'h0005, 16'h0000);
    chk(dev_addr_r, 7'h00);
    status(7'h00);
    chk(dev_addr_r, 7'h05);
    chk(state_r, `UEF_ST_ADDRESS);
    rx_n = 0;
    setup(7'h00, `UEF_REQ_GET_DESC, {`UEF_DT_DEVICE, 8'h00}, 16'h0008);
    read_pkt(7'h00);
    chk(rx_n, 16'h0000);
  endtask
  task t_config;
    rx_n = 0;
    setup(7'h05, `UEF_REQ_GET_DESC, {`UEF_DT_CONFIG, 8'h00}, 16'h0009);
    repeat (2) read_pkt(7'h05);
    chk(rx_n, 16'h0009);
    chk(rx_buf[1], 16'h0002);
    rx_n = 0;
    setup(7'h05, `UEF_REQ_GET_DESC, {`UEF_DT_CONFIG, 8'h00}, 16'h00FF);
    repeat (4) read_pkt(7'h05);
    chk(rx_n, 16'h0019);
    chk(rx_buf[2], 16'h0019);
    chk(rx_buf[9], 16'h0009);
    chk(rx_buf[18], 16'h0007);
    setup(7'h05, `UEF_REQ_SET_CONFIG, 16'h0001, 16'h0000);
    status(7'h05);
    chk(state_r, `UEF_ST_CONFIG);
    chk(ep_enable_r, 1'b1);
    chk(pwr_full_r, 1'b1);
    chk(pwr_low_r, 1'b0);
  endtask
  task t_detach;
    vbus_on = 1'b0;
    repeat (3) step;
    chk(state_r, `UEF_ST_POWERED);
    chk(dev_addr_r, 7'h00);
    chk(pwr_full_r, 1'b0);
    vbus_on = 1'b1;
    bus_reset;
    chk(state_r, `UEF_ST_DEFAULT);
    chk(n_rst_evt, 16'h0002);
    chk(n_state_evt, 16'h0005);
  endtask
  task close_out;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog over the whole run
  initial begin
    #(3000 * 100);
    n_mismatch++;
    close_out;
  end
  // Main sequence
  initial begin
    {rst_n, go_rst, setup_valid, in_req, status_done} = 5'h00;
    vbus_on = 1'b1;
    tok_addr = 7'h00;
    setup_req = 8'h00;
    setup_value = 16'h0000;
    setup_length = 16'h0000;
    repeat (8) @(posedge clk);
    #10;
    rst_n = 1'b1;
    repeat (3) step;
    t_attach;
    t_dev_desc;
    t_set_addr;
    t_config;
    t_detach;
    close_out;
  end
endmodule // uefsm_tb_top
